// File: logic/lsm_pkg.sv
package lsm_pkg;
  localparam int          REG_W           = 32;
  localparam int          NREG            = 16;
  localparam int          IDX_W           = 4;
  localparam logic [3:0]  SP_IDX          = 4'hd;
  localparam logic [3:0]  LR_IDX          = 4'he;
  localparam logic [3:0]  PC_IDX          = 4'hf;
  localparam logic [31:0] WORD_STEP       = 32'h0000_0004;
  localparam logic [31:0] WORD_ALIGN_MASK = 32'hffff_fffc;
  localparam logic [31:0] HALF_ALIGN_MASK = 32'hffff_fffe;
  localparam logic [11:0] LIT_OFF_MAX     = 12'hfff;
  localparam logic [11:0] PAIR_OFF_MAX    = 12'h3fc;
  localparam logic [15:0] LIT_FIRST_SLOT  = 16'h0001;
  localparam logic [15:0] LIT_PAIR_SLOTS  = 16'h0003;
  localparam logic [15:0] LIT_SECOND_SLOT = 16'h0002;

  typedef enum logic [2:0] {
    op_literal_load, op_literal_pair, op_load_multiple,
    op_store_multiple, op_stack_save, op_stack_restore
  } op_t;

  typedef enum logic [2:0] {
    mode_default, increment_after_mode, decrement_before_mode,
    full_descending_pop_alias, empty_ascending_pop_alias,
    empty_ascending_store_alias, full_descending_store_alias
  } mode_t;

  typedef enum logic [2:0] {
    unsigned_byte_type, signed_byte_type, unsigned_half_type,
    signed_half_type, word_type
  } ld_type_t;

  typedef struct packed {
    op_t             op;
    mode_t           mode;
    ld_type_t        ld_type;
    logic [3:0]      base_idx;
    logic            writeback;
    logic [15:0]     reg_list;
    logic [3:0]      target_idx;
    logic [3:0]      target2_idx;
    logic            off_neg;
    logic [11:0]     off_mag;
    logic [31:0]     pc;
    logic [31:0]     base_val;
  } cmd_t;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic [31:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic        en;
    logic [3:0]  idx;
    logic [31:0] data;
  } rf_wr_t;

  // Aliases have encodings of their own and map onto the plain ascending and descending forms
  function automatic logic mode_ascending(input mode_t m);
    case (m)
      decrement_before_mode, empty_ascending_pop_alias,
      full_descending_store_alias: mode_ascending = 1'b0;
      default:                     mode_ascending = 1'b1;
    endcase
  endfunction : mode_ascending
endpackage : lsm_pkg

// File: logic/reg_pick.sv
`timescale 1ns/100ps
module reg_pick
  import lsm_pkg::*;
#(
  parameter int N = 16
) (
  input  wire logic [N-1:0]           mask,
  input  wire logic                   ascending,
  output logic      [$clog2(N)-1:0]   idx
);
  logic [N:0]   below;
  logic [N:0]   above;
  logic [N-1:0] onehot;

  // Ripple chains mark set bits on either side of each position
  assign below[0] = 1'b0;
  assign above[N] = 1'b0;
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      assign below[i+1] = below[i] | mask[i];
      assign above[i]   = above[i+1] | mask[i];
      assign onehot[i]  = ascending ? (mask[i] & ~below[i]) : (mask[i] & ~above[i+1]);
    end
  endgenerate

  // Encode the single selected bit
  always_comb begin
    idx = '0;
    for (int k = 0; k < N; k++) begin
      if (onehot[k]) begin
        idx = idx | k[$clog2(N)-1:0];
      end
    end
  end
endmodule : reg_pick

// File: logic/load_extend.sv
`timescale 1ns/100ps
module load_extend
  import lsm_pkg::*;
(
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  lane,
  input  wire ld_type_t    ld_type,
  output logic      [31:0] ext
);
  logic [31:0] shifted;

  // Bring the addressed byte or half down to bit 0
  assign shifted = rdata >> {lane, 3'b000};

  // Zero or sign extension chosen by the load type
  always_comb begin
    case (ld_type)
      unsigned_byte_type: ext = {24'h00_0000, shifted[7:0]};
      signed_byte_type:   ext = {{24{shifted[7]}}, shifted[7:0]};
      unsigned_half_type: ext = {16'h0000, shifted[15:0]};
      signed_half_type:   ext = {{16{shifted[15]}}, shifted[15:0]};
      default:            ext = rdata;
    endcase
  end
endmodule : load_extend

// File: logic/load_store_multiple_address_gen.sv
`timescale 1ns/100ps
module load_store_multiple_address_gen
  import lsm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        cmd_valid,
  input  wire cmd_t        cmd,
  output logic             cmd_ready_r,
  output logic             illegal_r,
  output logic             mem_req_valid_r,
  output mem_req_t         mem_req_r,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  output logic      [3:0]  rf_rd_idx_r,
  input  wire logic [31:0] rf_rd_data,
  output rf_wr_t           rf_wr_r,
  output logic             branch_valid_r,
  output logic      [31:0] branch_target_r,
  output logic             flags_we_r
);
  typedef enum logic [2:0] {st_idle, st_read, st_issue, st_wait, st_wb} state_t;

  state_t      state_r;
  logic [15:0] rem_r;
  logic        asc_r;
  logic        load_r;
  logic        lit_r;
  ld_type_t    ld_type_r;
  logic [3:0]  target_r;
  logic [3:0]  target2_r;
  logic [3:0]  base_idx_r;
  logic        wb_r;
  logic [31:0] addr_r;
  logic [31:0] last_addr_r;
  logic [3:0]  cur_idx_r;
  logic        pc_hit_r;

  logic        accept;
  logic        is_lit;
  logic        is_stack;
  logic        cmd_load;
  logic        cmd_asc;
  logic        bad;
  logic [3:0]  cmd_base_idx;
  logic        cmd_wb;
  logic [31:0] pc_aligned;
  logic [31:0] lit_addr;
  logic [3:0]  pick_idx;
  logic [3:0]  cur_idx;
  logic [15:0] cur_mask;
  logic [15:0] rem_left;
  logic [31:0] ext_data;
  logic        ack;

  assign accept = cmd_valid && cmd_ready_r;
  assign ack    = mem_ack && mem_req_valid_r && state_r == st_wait;

  // Command decode; stack forms are fixed to the stack pointer with write-back
  always_comb begin
    is_lit       = cmd.op == op_literal_load || cmd.op == op_literal_pair;
    is_stack     = cmd.op == op_stack_save || cmd.op == op_stack_restore;
    cmd_load     = cmd.op != op_store_multiple && cmd.op != op_stack_save;
    cmd_base_idx = is_stack ? SP_IDX : cmd.base_idx;
    cmd_wb       = is_stack ? 1'b1 : cmd.writeback;
    case (cmd.op)
      op_stack_save:    cmd_asc = 1'b0;
      op_stack_restore: cmd_asc = 1'b1;
      op_literal_load,
      op_literal_pair:  cmd_asc = 1'b1;
      default:          cmd_asc = mode_ascending(cmd.mode);
    endcase
    pc_aligned = cmd.pc & WORD_ALIGN_MASK;
    lit_addr   = cmd.off_neg ? pc_aligned - {20'h0_0000, cmd.off_mag}
                             : pc_aligned + {20'h0_0000, cmd.off_mag};
  end

  // Encodings the core must never hand over are refused without any access
  always_comb begin
    bad = 1'b0;
    case (cmd.op)
      op_literal_load: begin
        bad = cmd.ld_type != word_type
              && (cmd.target_idx == SP_IDX || cmd.target_idx == PC_IDX);
        bad = bad || cmd.off_mag > LIT_OFF_MAX;
      end
      op_literal_pair: begin
        bad = cmd.off_mag > PAIR_OFF_MAX || cmd.off_mag[1:0] != 2'b00;
        bad = bad || cmd.target2_idx == SP_IDX || cmd.target2_idx == PC_IDX
              || cmd.target2_idx == cmd.target_idx
              || cmd.target_idx == SP_IDX || cmd.target_idx == PC_IDX;
      end
      default: begin
        bad = cmd.reg_list == 16'h0000;
        bad = bad || cmd.reg_list[SP_IDX] || cmd_base_idx == PC_IDX;
        bad = bad || (cmd_wb && cmd.reg_list[cmd_base_idx]);
        bad = bad || (!cmd_load && cmd.reg_list[PC_IDX]);
        bad = bad || (cmd_load && cmd.reg_list[PC_IDX]
                      && cmd.reg_list[LR_IDX]);
      end
    endcase
  end

  // Next register: lowest remaining when ascending, highest when descending
  reg_pick #(
    .N (NREG)
  ) u_pick (
    .mask      (rem_r),
    .ascending (asc_r),
    .idx       (pick_idx)
  );

  // Literal pairs walk two slots: first target, then second
  always_comb begin
    if (lit_r) begin
      cur_idx  = rem_r[0] ? target_r : target2_r;
      cur_mask = rem_r[0] ? LIT_FIRST_SLOT : LIT_SECOND_SLOT;
    end else begin
      cur_idx  = pick_idx;
      cur_mask = 16'h0001 << pick_idx;
    end
  end

  // Drop the slot just served; its mask is stable from read to ack
  assign rem_left = rem_r & ~cur_mask;

  // Sign or zero extension only for literal loads; multiples are words
  load_extend u_ext (
    .rdata   (mem_rdata),
    .lane    (mem_req_r.addr[1:0]),
    .ld_type (lit_r ? ld_type_r : word_type),
    .ext     (ext_data)
  );

  // Sequencer and per-command context
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= st_idle;
      rem_r       <= 16'h0000;
      asc_r       <= 1'b1;
      load_r      <= 1'b0;
      lit_r       <= 1'b0;
      ld_type_r   <= word_type;
      target_r    <= 4'h0;
      target2_r   <= 4'h0;
      base_idx_r  <= 4'h0;
      wb_r        <= 1'b0;
      addr_r      <= 32'h0000_0000;
      last_addr_r <= 32'h0000_0000;
      cur_idx_r   <= 4'h0;
      cmd_ready_r <= 1'b0;
    end else if (clk_en) begin
      case (state_r)
        st_idle: begin
          cmd_ready_r <= 1'b1;
          if (accept && !bad) begin
            cmd_ready_r <= 1'b0;
            state_r     <= st_read;
            lit_r       <= is_lit;
            load_r      <= cmd_load;
            asc_r       <= cmd_asc;
            ld_type_r   <= cmd.op == op_literal_pair ? word_type : cmd.ld_type;
            target_r    <= cmd.target_idx;
            target2_r   <= cmd.target2_idx;
            base_idx_r  <= cmd_base_idx;
            wb_r        <= !is_lit && cmd_wb;
            addr_r      <= is_lit ? lit_addr : cmd.base_val;
            case (cmd.op)
              op_literal_load: rem_r <= LIT_FIRST_SLOT;
              op_literal_pair: rem_r <= LIT_PAIR_SLOTS;
              default:         rem_r <= cmd.reg_list;
            endcase
          end
        end
        st_read: begin
          cur_idx_r <= cur_idx;
          state_r   <= st_issue;
        end
        st_issue: begin
          state_r <= st_wait;
        end
        st_wait: begin
          if (ack) begin
            rem_r       <= rem_left;
            last_addr_r <= mem_req_r.addr;
            addr_r      <= asc_r ? addr_r + WORD_STEP
                                 : addr_r - WORD_STEP;
            state_r     <= rem_left == 16'h0000 ? st_wb : st_read;
          end
        end
        st_wb: begin
          state_r     <= st_idle;
          cmd_ready_r <= 1'b1;
        end
        default: state_r <= st_idle;
      endcase
    end
  end

  // Memory request; store data is read one cycle after the index is set
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_req_valid_r <= 1'b0;
      mem_req_r       <= '0;
      rf_rd_idx_r     <= 4'h0;
    end else if (clk_en) begin
      if (state_r == st_read) begin
        rf_rd_idx_r <= cur_idx;
      end
      if (state_r == st_issue) begin
        mem_req_valid_r <= 1'b1;
        mem_req_r.addr  <= addr_r;
        mem_req_r.write <= !load_r;
        mem_req_r.wdata <= rf_rd_data;
      end else if (ack) begin
        mem_req_valid_r <= 1'b0;
      end
    end
  end

  // Register write port: loaded data, then the base write-back
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rf_wr_r <= '0;
    end else if (clk_en) begin
      rf_wr_r.en <= 1'b0;
      if (ack && load_r && cur_idx_r != PC_IDX) begin
        rf_wr_r.en   <= 1'b1;
        rf_wr_r.idx  <= cur_idx_r;
        rf_wr_r.data <= ext_data;
      end else if (state_r == st_wb && wb_r) begin
        rf_wr_r.en   <= 1'b1;
        rf_wr_r.idx  <= base_idx_r;
        rf_wr_r.data <= last_addr_r;
      end
    end
  end

  // A loaded counter waits for the write-back state, then branches once, in the same cycle as the base write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc_hit_r        <= 1'b0;
      branch_valid_r  <= 1'b0;
      branch_target_r <= 32'h0000_0000;
    end else if (clk_en) begin
      branch_valid_r <= 1'b0;
      if (ack && load_r && cur_idx_r == PC_IDX) begin
        pc_hit_r        <= 1'b1;
        branch_target_r <= ext_data & HALF_ALIGN_MASK;
      end else if (state_r == st_wb) begin
        pc_hit_r       <= 1'b0;
        branch_valid_r <= pc_hit_r;
      end
    end
  end

  // Refusal pulse; flags port stays idle since nothing here sets flags
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      illegal_r  <= 1'b0;
      flags_we_r <= 1'b0;
    end else if (clk_en) begin
      illegal_r  <= accept && bad;
      flags_we_r <= 1'b0;
    end
  end

  // Checks; in those disabled on !clk_en a frozen cycle abandons any attempt in flight
  AST_NO_FLAGS: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r != st_idle) |-> !flags_we_r)
    else $error("flag write during a transfer");

  AST_LIT_ADDR: assert property (@(posedge clock) disable iff (!rst_n || !clk_en)
    (accept && !bad && is_lit) |-> ##3 (mem_req_valid_r && mem_req_r.addr == $past(lit_addr, 3)))
    else $error("literal address not aligned counter plus offset");

  AST_STEP_UP: assert property (@(posedge clock) disable iff (!rst_n || !clk_en)
    (ack && asc_r && rem_left != 16'h0000)
      |-> ##3 (mem_req_r.addr == $past(mem_req_r.addr, 3) + WORD_STEP))
    else $error("ascending step is not four bytes");

  AST_STEP_DOWN: assert property (@(posedge clock) disable iff (!rst_n || !clk_en)
    (ack && !asc_r && rem_left != 16'h0000)
      |-> ##3 (mem_req_r.addr == $past(mem_req_r.addr, 3) - WORD_STEP))
    else $error("descending step is not four bytes");

  AST_ASC_ORDER: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == st_wait && asc_r && !lit_r)
      |-> ((rem_r & ((16'h0001 << cur_idx_r) - 16'h0001)) == 16'h0000))
    else $error("lower register left behind in ascending walk");

  AST_DESC_ORDER: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == st_wait && !asc_r)
      |-> ((rem_r & ~((16'h0002 << cur_idx_r) - 16'h0001)) == 16'h0000))
    else $error("higher register left behind in descending walk");

  AST_WB: assert property (@(posedge clock) disable iff (!rst_n || !clk_en)
    (state_r == st_wb && wb_r) |=> (rf_wr_r.en && rf_wr_r.idx == $past(base_idx_r)
                                    && rf_wr_r.data == $past(last_addr_r)))
    else $error("write-back value or register wrong");

  AST_BRANCH: assert property (@(posedge clock) disable iff (!rst_n)
    branch_valid_r |-> (branch_target_r[0] == 1'b0 && $past(state_r) == st_wb))
    else $error("branch target not halfword aligned");

  AST_SB_EXT: assert property (@(posedge clock) disable iff (!rst_n)
    (rf_wr_r.en && lit_r && ld_type_r == signed_byte_type && state_r != st_idle)
      |-> (rf_wr_r.data[31:8] == {24{rf_wr_r.data[7]}}))
    else $error("signed byte not sign extended");

  AST_STACK_BASE: assert property (@(posedge clock) disable iff (!rst_n || !clk_en)
    (accept && !bad && is_stack) |=> (base_idx_r == SP_IDX && wb_r))
    else $error("stack form not based on stack pointer");

  AST_SH_EXT: assert property (@(posedge clock) disable iff (!rst_n)
    (rf_wr_r.en && lit_r && ld_type_r == signed_half_type && state_r != st_idle)
      |-> (rf_wr_r.data[31:16] == {16{rf_wr_r.data[15]}}))
    else $error("signed half not sign extended");

  AST_UB_EXT: assert property (@(posedge clock) disable iff (!rst_n)
    (rf_wr_r.en && lit_r && ld_type_r == unsigned_byte_type && state_r != st_idle)
      |-> (rf_wr_r.data[31:8] == 24'h00_0000))
    else $error("unsigned byte not zero extended");

  AST_REFUSE: assert property (@(posedge clock) disable iff (!rst_n || !clk_en)
    (accept && bad) |=> (illegal_r && cmd_ready_r && !mem_req_valid_r))
    else $error("refused command started a transfer");

  AST_PC_NOT_WRITTEN: assert property (@(posedge clock) disable iff (!rst_n || !clk_en)
    (ack && load_r && cur_idx_r == PC_IDX) |=> !rf_wr_r.en)
    else $error("loaded counter went to the register file");

  AST_STORE_NO_PC: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == st_wait && !load_r) |-> (cur_idx_r != PC_IDX))
    else $error("counter stored by a multiple store");

  COV_PAIR: cover property (@(posedge clock) disable iff (!rst_n)
    accept && !bad && cmd.op == op_literal_pair);
  COV_SAVE: cover property (@(posedge clock) disable iff (!rst_n)
    state_r == st_wb && wb_r && !asc_r);
  COV_POP_PC: cover property (@(posedge clock) disable iff (!rst_n)
    branch_valid_r && !lit_r);
  COV_LIT_BRANCH: cover property (@(posedge clock) disable iff (!rst_n)
    branch_valid_r && lit_r);
  COV_DESC_LOAD: cover property (@(posedge clock) disable iff (!rst_n)
    state_r == st_wb && load_r && !asc_r);
endmodule : load_store_multiple_address_gen

// File: tb/mem_core_model.sv
`timescale 1ns/100ps
module mem_core_model
  import lsm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic        req_valid,
  input  wire mem_req_t    req,
  input  wire logic [3:0]  rd_idx,
  output logic             ack,
  output logic      [31:0] rdata,
  output logic      [31:0] rd_data
);
  logic [1:0] wait_r;

  // Register file: index in low bits so a swapped read shows up
  assign rd_data = 32'hc0de_0000 + {28'h0, rd_idx};

  // Ack after zero or three cycles; word data only while acking
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack    <= 1'b0;
      wait_r <= 2'h0;
      rdata  <= 32'h0;
    end else if (ack) begin
      ack    <= 1'b0;
      wait_r <= 2'h0;
      rdata  <= ~rdata; // Released bus must not keep old data
    end else if (req_valid && (!slow || wait_r == 2'h3)) begin
      ack   <= 1'b1;
      rdata <= (req.addr & WORD_ALIGN_MASK) ^ 32'h96c3_5af1;
    end else begin
      wait_r <= req_valid ? wait_r + 2'h1 : 2'h0;
      rdata  <= ~rdata;
    end
  end
endmodule : mem_core_model

// File: tb/load_store_multiple_address_gen_test.sv
`timescale 1ns/100ps
module load_store_multiple_address_gen_test
  import lsm_pkg::*;
;
  logic        clock, rst_n, clk_en, cmd_valid, slow, mem_ack;
  cmd_t        cmd;
  logic        cmd_ready_r, illegal_r, mem_req_valid_r, branch_valid_r, flags_we_r;
  mem_req_t    mem_req_r;
  logic [31:0] mem_rdata, rf_rd_data, branch_target_r;
  logic [3:0]  rf_rd_idx_r;
  rf_wr_t      rf_wr_r;
  mem_req_t    acc_q[$];
  rf_wr_t      wr_q[$];
  logic [31:0] br_q[$];
  int          error_cnt, num_checks, ill_cnt, flag_cnt, cycles;

  load_store_multiple_address_gen dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready_r(cmd_ready_r), .illegal_r(illegal_r),
    .mem_req_valid_r(mem_req_valid_r), .mem_req_r(mem_req_r), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .rf_rd_idx_r(rf_rd_idx_r), .rf_rd_data(rf_rd_data),
    .rf_wr_r(rf_wr_r), .branch_valid_r(branch_valid_r), .branch_target_r(branch_target_r),
    .flags_we_r(flags_we_r));

  mem_core_model far (.clock(clock), .rst_n(rst_n), .slow(slow), .req_valid(mem_req_valid_r),
    .req(mem_req_r), .rd_idx(rf_rd_idx_r), .ack(mem_ack), .rdata(mem_rdata),
    .rd_data(rf_rd_data));

  always #10 clock = ~clock;

  // Monitor: records every handshake and pulse, and cuts a hang short
  always @(posedge clock) begin
    cycles++;
    if (mem_req_valid_r && mem_ack) acc_q.push_back(mem_req_r);
    if (rf_wr_r.en) wr_q.push_back(rf_wr_r);
    if (branch_valid_r) br_q.push_back(branch_target_r);
    if (illegal_r) ill_cnt++;
    if (flags_we_r) flag_cnt++;
    if (cycles > 20000) begin
      error_cnt++;
      conclude();
    end
  end

  function automatic logic [31:0] mem_word(input logic [31:0] a);
    return (a & 32'hffff_fffc) ^ 32'h96c3_5af1;
  endfunction : mem_word

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // One command, then wait for ready to return and trailing pulses to land
  task automatic issue(input cmd_t c);
    int k;
    acc_q.delete();
    wr_q.delete();
    br_q.delete();
    ill_cnt = 0;
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd       <= c;
    @(posedge clock);
    cmd_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge clock);
      #1;
      k++;
    end while (cmd_ready_r !== 1'b1 && k < 300);
    if (k >= 300) error_cnt++;
    repeat (2) @(posedge clock);
    #1;
  endtask : issue

  // Multiple transfer: order, addresses, data, write-back worked out here
  task automatic multi(input op_t op, input mode_t md, input logic [3:0] bi,
                       input logic [15:0] lst, input logic wb);
    cmd_t        c;
    logic        asc, ld;
    logic [31:0] a, base;
    int          k, w, r;
    c = '0;
    base = 32'h2000_0400;
    c.op = op;
    c.mode = md;
    c.base_idx = bi;
    c.writeback = wb;
    c.reg_list = lst;
    c.base_val = base;
    asc = op == op_stack_restore || (op != op_stack_save &&
          !(md inside {decrement_before_mode, empty_ascending_pop_alias,
                       full_descending_store_alias}));
    ld = op inside {op_load_multiple, op_stack_restore};
    issue(c);
    check("access count", $countones(lst), acc_q.size());
    k = 0;
    w = 0;
    for (int i = 0; i < 16; i++) begin
      r = asc ? i : 15 - i;
      if (lst[r] && k < acc_q.size()) begin
        a = asc ? base + 32'(4 * k) : base - 32'(4 * k);
        check("address", a, acc_q[k].addr);
        check("write flag", {31'h0, !ld}, {31'h0, acc_q[k].write});
        if (!ld) check("store data", 32'hc0de_0000 + r, acc_q[k].wdata);
        else if (r == 15) check("branch", mem_word(a) & HALF_ALIGN_MASK, br_q[0]);
        else if (w < wr_q.size()) begin
          check("load index", r, {28'h0, wr_q[w].idx});
          check("load data", mem_word(a), wr_q[w].data);
          w++;
        end
        k++;
      end
    end
    if (ld && lst[15]) check("branch count", 1, br_q.size());
    check("reg writes", (ld ? $countones(lst[14:0]) : 0) + wb, wr_q.size());
    a = asc ? base + 32'(4 * (k - 1)) : base - 32'(4 * (k - 1));
    if (wb && wr_q.size() > w) begin
      check("writeback index", {28'h0, bi}, {28'h0, wr_q[w].idx});
      check("writeback value", a, wr_q[w].data);
    end
  endtask : multi

  task automatic test_default_mode();
    multi(op_load_multiple, mode_default, 4'h8, 16'h0205, 1'b1);
    multi(op_store_multiple, mode_default, 4'h3, 16'h0001, 1'b0);
    $display("test default mode done");
  endtask : test_default_mode

  task automatic test_all_modes();
    for (int m = 1; m < 7; m++) begin
      multi(op_store_multiple, mode_t'(m), 4'h1, 16'h1878, 1'b1);
      multi(op_load_multiple, mode_t'(m), 4'h8, 16'h8205, m[0]);
    end
    $display("test all modes done");
  endtask : test_all_modes

  task automatic test_stack();
    @(posedge clock);
    slow <= 1'b1;
    multi(op_stack_save, mode_default, 4'hd, 16'h40f1, 1'b1);
    multi(op_stack_restore, mode_default, 4'hd, 16'h8401, 1'b1);
    @(posedge clock);
    slow <= 1'b0;
    $display("test stack done");
  endtask : test_stack

  // Literal: word-aligned counter plus offset, lane picked, extended by type
  task automatic literal(input ld_type_t t, input logic [3:0] ti, input logic neg,
                         input logic [11:0] off);
    cmd_t        c;
    logic [31:0] a, w, e;
    c = '0;
    c.op = op_literal_load;
    c.ld_type = t;
    c.target_idx = ti;
    c.off_neg = neg;
    c.off_mag = off;
    c.pc = 32'h0000_1006;
    a = neg ? 32'h1004 - {20'h0, off} : 32'h1004 + {20'h0, off};
    issue(c);
    w = mem_word(a) >> {a[1:0], 3'b000};
    case (t)
      unsigned_byte_type: e = {24'h0, w[7:0]};
      signed_byte_type:   e = {{24{w[7]}}, w[7:0]};
      unsigned_half_type: e = {16'h0, w[15:0]};
      signed_half_type:   e = {{16{w[15]}}, w[15:0]};
      default:            e = mem_word(a);
    endcase
    check("literal accesses", 1, acc_q.size());
    if (acc_q.size() > 0) check("literal address", a, acc_q[0].addr);
    if (ti == 4'hf) check("literal branch", e & HALF_ALIGN_MASK, br_q[0]);
    else if (wr_q.size() > 0) check("literal data", e, wr_q[0].data);
  endtask : literal

  task automatic test_literal();
    logic [11:0] off;
    for (int t = 0; t < 5; t++) begin
      off = t < 2 ? 12'hfff : t < 4 ? 12'hffe : 12'hffc;
      literal(ld_type_t'(t), 4'h2, ~t[0], off);
    end
    literal(word_type, 4'hf, 1'b1, 12'h008);
    $display("test literal done");
  endtask : test_literal

  task automatic test_pair();
    cmd_t        c;
    logic [31:0] a;
    c = '0;
    c.op = op_literal_pair;
    c.ld_type = word_type;
    c.target_idx = 4'h4;
    c.target2_idx = 4'h5;
    c.off_neg = 1'b1;
    c.off_mag = 12'h3fc;
    c.pc = 32'h0000_1006;
    a = 32'h1004 - 32'h3fc;
    issue(c);
    check("pair accesses", 2, acc_q.size());
    check("pair writes", 2, wr_q.size());
    if (acc_q.size() == 2 && wr_q.size() == 2) begin
      check("pair address 1", a, acc_q[0].addr);
      check("pair address 2", a + 32'h4, acc_q[1].addr);
      check("pair data 2", mem_word(a + 32'h4), wr_q[1].data);
      check("pair index 1", 4, {28'h0, wr_q[0].idx});
    end
    $display("test pair done");
  endtask : test_pair

  task automatic refused(input cmd_t c);
    issue(c);
    check("refusal pulse", 1, ill_cnt);
    check("refused accesses", 0, acc_q.size());
  endtask : refused

  task automatic test_refused();
    cmd_t c;
    c = '0;
    c.op = op_load_multiple;
    c.base_idx = 4'h8;
    refused(c);
    c.reg_list = 16'h2001;
    refused(c);
    c.reg_list = 16'h0001;
    c.base_idx = 4'hf;
    refused(c);
    c.base_idx = 4'h0;
    c.writeback = 1'b1;
    refused(c);
    c.writeback = 1'b0;
    c.reg_list = 16'hc001;
    refused(c);
    c.op = op_store_multiple;
    c.reg_list = 16'h8001;
    refused(c);
    c.op = op_stack_save;
    refused(c);
    c = '0;
    c.target_idx = 4'hf;
    refused(c);
    c.op = op_literal_pair;
    c.ld_type = word_type;
    c.target_idx = 4'h4;
    c.target2_idx = 4'h4;
    refused(c);
    c.target2_idx = 4'h5;
    c.off_mag = 12'h400;
    refused(c);
    check("flag writes", 0, flag_cnt);
    $display("test refused done");
  endtask : test_refused

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    slow = 1'b0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    test_default_mode();
    test_all_modes();
    test_stack();
    test_literal();
    test_pair();
    test_refused();
    conclude();
  end
endmodule : load_store_multiple_address_gen_test
